// File: isr_ctl_model.sv
// bus controller model: one Avalon-MM access per go request
`timescale 1ns/10ps
module isr_ctl_model (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire isr_pkg::isr_avs_rsp_t i_avs,
	output isr_pkg::isr_avs_req_t o_avs,
	output logic o_done,
	output logic [31:0] o_rdata
);
	import isr_pkg::*;
	// hold request until waitrequest low, then release
	always_ff @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		if (i_rst) begin
			o_avs <= '0;
		end else if (o_avs.read | o_avs.write) begin
			if (!i_avs.waitrequest) begin
				o_avs.read <= 1'b0;
				o_avs.write <= 1'b0;
				o_avs.writedata <= ~o_avs.writedata;
				o_rdata <= i_avs.readdata;
				o_done <= 1'b1;
			end
		end else if (i_go) begin
			o_avs <= '{i_rd, !i_rd, i_addr, i_wdata};
		end
	end
endmodule : isr_ctl_model

// File: isr_pkg.sv
// constants, carriers and state codes of the status reporting block
package isr_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_STB = 8'h00;
	localparam logic [7:0] ADR_POLL = 8'h04;
	localparam logic [7:0] ADR_SRE = 8'h08;
	localparam logic [7:0] ADR_ESE = 8'h0C;
	localparam logic [7:0] ADR_ESR = 8'h10;
	localparam logic [7:0] ADR_PSC = 8'h14;
	localparam logic [7:0] ADR_CLS = 8'h18;
	localparam logic [7:0] ADR_PRESET = 8'h1C;
	localparam logic [7:0] ADR_MSG = 8'h20;
	localparam logic [7:0] ADR_ABN_BASE = 8'h40;
	localparam logic [7:0] ADR_NORM_BASE = 8'h60;
	localparam logic [7:0] GRP_COND = 8'h00;
	localparam logic [7:0] GRP_RISE = 8'h04;
	localparam logic [7:0] GRP_FALL = 8'h08;
	localparam logic [7:0] GRP_EVENT = 8'h0C;
	localparam logic [7:0] GRP_ENABLE = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int STB_ABN_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;
	localparam int STB_NORM_BIT = 7;
	localparam int ESR_PON_BIT = 7;
	localparam int MSG_VALID_BIT = 8;
	localparam logic [7:0] SRE_MASK = 8'hBF;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] ESR_RST = 8'h80;
	localparam logic [7:0] ESE_RST = 8'h00;
	localparam logic [7:0] SRE_RST = 8'h00;
	localparam logic PSC_RST = 1'b0;
	localparam logic [1:0] INIT_SYNC_CYC = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} isr_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} isr_avs_rsp_t;

	typedef struct packed {
		logic preset;
		logic cls;
		logic wr_rise;
		logic wr_fall;
		logic wr_enable;
		logic rd_event;
	} isr_grp_ctl_t;

	typedef enum logic [2:0] {
		ST_SYNC = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN = 3'b100
	} isr_init_t;

endpackage : isr_pkg

// File: isr_status_group.sv
// one condition / transition filter / event / enable status group
`timescale 1ns/10ps
module isr_status_group #(
	parameter int GW = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [GW-1:0] i_cond,
	input wire isr_pkg::isr_grp_ctl_t i_ctl,
	input wire logic [GW-1:0] i_wdata,
	output logic [GW-1:0] o_rise,
	output logic [GW-1:0] o_fall,
	output logic [GW-1:0] o_event,
	output logic [GW-1:0] o_enable,
	output logic o_summary
);
	import isr_pkg::*;

	logic [GW-1:0] cond_q;
	logic [GW-1:0] next_hit;

	// ----------------------------------------------------------------
	// transition filters and enable mask
	// ----------------------------------------------------------------
	// [R16] rising filter preset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_ctl.preset) begin
			o_rise <= '1;
		end else if (i_ctl.wr_rise) begin
			o_rise <= i_wdata;
		end
	end

	// [R17] falling filter preset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_ctl.preset) begin
			o_fall <= '0;
		end else if (i_ctl.wr_fall) begin
			o_fall <= i_wdata;
		end
	end

	// [R18] enable mask preset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_ctl.preset) begin
			o_enable <= '0;
		end else if (i_ctl.wr_enable) begin
			o_enable <= i_wdata;
		end
	end

	// ----------------------------------------------------------------
	// event latch
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cond_q <= '0;
		end else begin
			cond_q <= i_cond;
		end
	end

	// [R22] filtered edge detect
	assign next_hit = (i_cond & ~cond_q & o_rise) | (~i_cond & cond_q & o_fall);

	// [R2] same register set
	// [R11] read clears, new edge wins
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_event <= '0;
		end else if (i_ctl.rd_event || i_ctl.cls) begin
			o_event <= next_hit;
		end else begin
			o_event <= o_event | next_hit;
		end
	end

	// [R24] live masked summary
	assign o_summary = |(o_event & o_enable);

endmodule : isr_status_group

// File: isr_status_top.sv
// status reporting: groups, standard events, summary byte, service request, output queue
// Operation
// [R1] abnormal group ORed into summary byte bit 3.
// [R2] abnormal group has condition, rising, falling, event and enable registers.
// [R3] standard event latch is read-only and cleared by every read.
// [R4] masked standard events ORed into summary byte bit 5.
// [R5] standard event enable zeroed at power-on when persistence clear is one.
// [R6] poll and query return same byte except bit 6.
// [R7] service request raises request line and latches request flag in bit 6.
// [R8] serial poll returns request flag, then clears it, others untouched.
// [R9] master summary is a live OR of mask-enabled summary bits.
// [R10] status byte query clears nothing.
// [R11] reading an event register clears it and drops its summary.
// [R12] service request mask selects bits; all zero means no requests.
// [R13] output queue is FIFO; bit 4 set while it holds a byte.
// [R14] too many unread errors produce a system error message.
// [R15] queue emptied at power-on and by clear status.
// [R16] power-on preset sets all rising filter bits.
// [R17] power-on preset clears all falling filter bits.
// [R18] power-on clears events, summary byte, queue and group enables.
// [R19] masks zeroed if persistence is one, else restored from storage.
// [R20] powerup flag bit 7 set at every power-up.
// [R21] controller sets enable bit 7 and mask bit 5 for power-loss requests.
// [R22] event register latches filtered changes until cleared.
// [R23] normal-operation summary sits at summary byte bit 7.
// [R24] group summaries are combinational masked ORs.
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module isr_status_top #(
	parameter int GRP_W = 16,
	parameter int Q_DEPTH = 16,
	parameter int ERR_LIMIT = 4,
	parameter logic [7:0] SYS_ERR_CODE = 8'hEE
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire isr_pkg::isr_avs_req_t i_avs,
	output isr_pkg::isr_avs_rsp_t o_avs,
	input wire logic [GRP_W-1:0] i_abn_cond,
	input wire logic [GRP_W-1:0] i_norm_cond,
	input wire logic [7:0] i_std_evt,
	input wire logic i_msg_valid,
	input wire logic [7:0] i_msg_data,
	input wire logic i_msg_err,
	output logic o_msg_ready,
	input wire logic i_nv_psc,
	input wire logic [7:0] i_nv_ese,
	input wire logic [7:0] i_nv_sre,
	output logic o_nv_psc,
	output logic [7:0] o_nv_ese,
	output logic [7:0] o_nv_sre,
	output logic o_srq
);
	import isr_pkg::*;

	localparam int QW = $clog2(Q_DEPTH);

	generate
		if (GRP_W < 1 || GRP_W > 32) begin : g_bad_w
			$error("group width must be 1 to 32");
		end
		if (Q_DEPTH < 2 || (1 << QW) != Q_DEPTH) begin : g_bad_q
			$error("queue depth must be a power of two");
		end
		if (ERR_LIMIT < 1 || ERR_LIMIT >= Q_DEPTH) begin : g_bad_e
			$error("error limit must be below queue depth");
		end
	endgenerate

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [GRP_W-1:0] abn_m, abn_s, norm_m, norm_s;
	logic nv_psc_m, nv_psc_s;
	logic [7:0] nv_ese_m, nv_ese_s, nv_sre_m, nv_sre_s;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			abn_m <= '0;
			abn_s <= '0;
			norm_m <= '0;
			norm_s <= '0;
		end else begin
			abn_m <= i_abn_cond;
			abn_s <= abn_m;
			norm_m <= i_norm_cond;
			norm_s <= norm_m;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			nv_psc_m <= 1'b0;
			nv_psc_s <= 1'b0;
			nv_ese_m <= 8'h00;
			nv_ese_s <= 8'h00;
			nv_sre_m <= 8'h00;
			nv_sre_s <= 8'h00;
		end else begin
			nv_psc_m <= i_nv_psc;
			nv_psc_s <= nv_psc_m;
			nv_ese_m <= i_nv_ese;
			nv_ese_s <= nv_ese_m;
			nv_sre_m <= i_nv_sre;
			nv_sre_s <= nv_sre_m;
		end
	end

	// ----------------------------------------------------------------
	// power-on sequence
	// ----------------------------------------------------------------
	isr_init_t state;
	logic [1:0] init_cnt;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= ST_SYNC;
			init_cnt <= 2'h0;
		end else begin
			unique case (state)
				ST_SYNC: begin
					init_cnt <= init_cnt + 2'h1;
					if (init_cnt == INIT_SYNC_CYC - 2'h1) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					state <= ST_RUN;
				end
				ST_RUN: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus slave decode
	// ----------------------------------------------------------------
	logic wait_q;
	logic take, take_rd, take_wr;
	logic rd_stb, rd_poll, rd_esr, rd_msg, wr_sre, wr_ese, wr_psc, cls_op, preset_op;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;

	assign take = (i_avs.read || i_avs.write) && wait_q && (state == ST_RUN);
	assign take_rd = take && i_avs.read;
	assign take_wr = take && i_avs.write;
	assign rd_stb = take_rd && (i_avs.address == ADR_STB);
	assign rd_poll = take_rd && (i_avs.address == ADR_POLL);
	assign rd_esr = take_rd && (i_avs.address == ADR_ESR);
	assign rd_msg = take_rd && (i_avs.address == ADR_MSG);
	assign wr_sre = take_wr && (i_avs.address == ADR_SRE);
	assign wr_ese = take_wr && (i_avs.address == ADR_ESE);
	assign wr_psc = take_wr && (i_avs.address == ADR_PSC);
	assign cls_op = take_wr && (i_avs.address == ADR_CLS);
	assign preset_op = take_wr && (i_avs.address == ADR_PRESET);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~take;
		end
	end

	// ----------------------------------------------------------------
	// status groups
	// ----------------------------------------------------------------
	isr_grp_ctl_t abn_ctl, norm_ctl;
	logic [GRP_W-1:0] abn_rise, abn_fall, abn_evt, abn_en;
	logic [GRP_W-1:0] norm_rise, norm_fall, norm_evt, norm_en;
	logic abn_sum, norm_sum;

	always_comb begin
		abn_ctl.preset = preset_op;
		abn_ctl.cls = cls_op;
		abn_ctl.wr_rise = take_wr && (i_avs.address == ADR_ABN_BASE + GRP_RISE);
		abn_ctl.wr_fall = take_wr && (i_avs.address == ADR_ABN_BASE + GRP_FALL);
		abn_ctl.wr_enable = take_wr && (i_avs.address == ADR_ABN_BASE + GRP_ENABLE);
		abn_ctl.rd_event = take_rd && (i_avs.address == ADR_ABN_BASE + GRP_EVENT);
		norm_ctl.preset = preset_op;
		norm_ctl.cls = cls_op;
		norm_ctl.wr_rise = take_wr && (i_avs.address == ADR_NORM_BASE + GRP_RISE);
		norm_ctl.wr_fall = take_wr && (i_avs.address == ADR_NORM_BASE + GRP_FALL);
		norm_ctl.wr_enable = take_wr && (i_avs.address == ADR_NORM_BASE + GRP_ENABLE);
		norm_ctl.rd_event = take_rd && (i_avs.address == ADR_NORM_BASE + GRP_EVENT);
	end

	isr_status_group #(.GW(GRP_W)) u_abn (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_cond(abn_s),
		.i_ctl(abn_ctl),
		.i_wdata(i_avs.writedata[GRP_W-1:0]),
		.o_rise(abn_rise),
		.o_fall(abn_fall),
		.o_event(abn_evt),
		.o_enable(abn_en),
		.o_summary(abn_sum)
	);

	isr_status_group #(.GW(GRP_W)) u_norm (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_cond(norm_s),
		.i_ctl(norm_ctl),
		.i_wdata(i_avs.writedata[GRP_W-1:0]),
		.o_rise(norm_rise),
		.o_fall(norm_fall),
		.o_event(norm_evt),
		.o_enable(norm_en),
		.o_summary(norm_sum)
	);

	// ----------------------------------------------------------------
	// standard events, masks, persistence
	// ----------------------------------------------------------------
	logic [7:0] esr, ese, sre;
	logic persistence_clear_setting;

	// [R3] read-only, read clears
	// [R20] powerup flag at reset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			esr <= ESR_RST;
		end else if (rd_esr || cls_op) begin
			esr <= i_std_evt;
		end else begin
			esr <= esr | i_std_evt;
		end
	end

	// [R5] persistence clears enable
	// [R19] restore or zero masks
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ese <= ESE_RST;
			sre <= SRE_RST;
			persistence_clear_setting <= PSC_RST;
		end else if (state == ST_LOAD) begin
			persistence_clear_setting <= nv_psc_s;
			ese <= nv_psc_s ? ESE_RST : nv_ese_s;
			sre <= nv_psc_s ? SRE_RST : (nv_sre_s & SRE_MASK);
		end else begin
			if (wr_ese) begin
				ese <= i_avs.writedata[7:0];
			end
			if (wr_sre) begin
				sre <= i_avs.writedata[7:0] & SRE_MASK;
			end
			if (wr_psc) begin
				persistence_clear_setting <= i_avs.writedata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// output queue
	// ----------------------------------------------------------------
	logic [8:0] q_mem [Q_DEPTH];
	logic [QW-1:0] q_wptr, q_rptr;
	logic [QW:0] q_count, err_cnt, next_q_count, next_err_cnt;
	logic msg_room, sys_err_sent, msg_take, err_full, push, pop;
	logic [8:0] push_word;

	assign msg_take = i_msg_valid && msg_room && (state == ST_RUN);
	assign err_full = err_cnt >= (QW+1)'(ERR_LIMIT);
	// [R14] system error on error overflow
	assign push = msg_take && !(i_msg_err && err_full && sys_err_sent);
	assign push_word = (i_msg_err && err_full) ? {1'b0, SYS_ERR_CODE} : {i_msg_err, i_msg_data};
	assign pop = rd_msg && (q_count != '0);

	always_comb begin
		next_q_count = q_count + {{QW{1'b0}}, push} - {{QW{1'b0}}, pop};
		next_err_cnt = err_cnt + {{QW{1'b0}}, push && push_word[8]}
			- {{QW{1'b0}}, pop && q_mem[q_rptr][8]};
	end

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			q_mem[q_wptr] <= push_word;
		end
	end

	// [R13] first-in first-out order
	// [R15] emptied at reset and clear
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || cls_op) begin
			q_wptr <= '0;
			q_rptr <= '0;
			q_count <= '0;
			err_cnt <= '0;
			msg_room <= 1'b1;
			sys_err_sent <= 1'b0;
		end else begin
			if (push) begin
				q_wptr <= q_wptr + 1'b1;
			end
			if (pop) begin
				q_rptr <= q_rptr + 1'b1;
			end
			q_count <= next_q_count;
			err_cnt <= next_err_cnt;
			msg_room <= next_q_count < (QW+1)'(Q_DEPTH);
			if (msg_take && i_msg_err && err_full) begin
				sys_err_sent <= 1'b1;
			end else if (!err_full) begin
				sys_err_sent <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// summary byte and service request
	// ----------------------------------------------------------------
	logic [7:0] stb_base;
	logic esb, message_available_flag, master_summary_flag, mss_q, request_service_flag;

	// [R4] masked standard events
	assign esb = |(esr & ese);
	assign message_available_flag = (q_count != '0);

	// [R1] abnormal at bit 3
	// [R23] normal at bit 7
	always_comb begin
		stb_base = 8'h00;
		stb_base[STB_ABN_BIT] = abn_sum;
		stb_base[STB_MAV_BIT] = message_available_flag;
		stb_base[STB_ESB_BIT] = esb;
		stb_base[STB_NORM_BIT] = norm_sum;
	end

	// [R9] live masked OR
	// [R12] mask selects request
	assign master_summary_flag = |(stb_base & sre & SRE_MASK);

	// [R7] latch request flag
	// [R8] poll clears flag
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			mss_q <= 1'b0;
			request_service_flag <= 1'b0;
		end else begin
			mss_q <= master_summary_flag;
			request_service_flag <= (master_summary_flag && !mss_q) || (request_service_flag && !(rd_poll || cls_op));
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// [R6] bit 6 differs per path
	// [R10] query clears nothing
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_avs.address)
			ADR_STB: rd_mux[7:0] = stb_base | ({7'h00, master_summary_flag} << STB_RQS_BIT);
			ADR_POLL: rd_mux[7:0] = stb_base | ({7'h00, request_service_flag} << STB_RQS_BIT);
			ADR_SRE: rd_mux[7:0] = sre;
			ADR_ESE: rd_mux[7:0] = ese;
			ADR_ESR: rd_mux[7:0] = esr;
			ADR_PSC: rd_mux[0] = persistence_clear_setting;
			ADR_MSG: rd_mux[MSG_VALID_BIT:0] = {message_available_flag, q_mem[q_rptr][7:0]};
			ADR_ABN_BASE + GRP_COND: rd_mux[GRP_W-1:0] = abn_s;
			ADR_ABN_BASE + GRP_RISE: rd_mux[GRP_W-1:0] = abn_rise;
			ADR_ABN_BASE + GRP_FALL: rd_mux[GRP_W-1:0] = abn_fall;
			ADR_ABN_BASE + GRP_EVENT: rd_mux[GRP_W-1:0] = abn_evt;
			ADR_ABN_BASE + GRP_ENABLE: rd_mux[GRP_W-1:0] = abn_en;
			ADR_NORM_BASE + GRP_COND: rd_mux[GRP_W-1:0] = norm_s;
			ADR_NORM_BASE + GRP_RISE: rd_mux[GRP_W-1:0] = norm_rise;
			ADR_NORM_BASE + GRP_FALL: rd_mux[GRP_W-1:0] = norm_fall;
			ADR_NORM_BASE + GRP_EVENT: rd_mux[GRP_W-1:0] = norm_evt;
			ADR_NORM_BASE + GRP_ENABLE: rd_mux[GRP_W-1:0] = norm_en;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (take_rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign o_avs = '{readdata: rdata_q, waitrequest: wait_q};
	assign o_msg_ready = msg_room;
	assign o_srq = request_service_flag;
	assign o_nv_psc = persistence_clear_setting;
	assign o_nv_ese = ese;
	assign o_nv_sre = sre;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	property p_abn_bit;
		rd_stb |=> o_avs.readdata[STB_ABN_BIT] == $past(|(abn_evt & abn_en));
	endproperty
	a_abn_bit: assert property (p_abn_bit) else $error("abnormal summary wrong"); // [R1]

	property p_esr_clear;
		rd_esr && (i_std_evt == 8'h00) |=> (esr == 8'h00) && !o_avs.waitrequest;
	endproperty
	a_esr_clear: assert property (p_esr_clear) else $error("event latch not cleared"); // [R3]

	property p_esb_bit;
		rd_stb |=> o_avs.readdata[STB_ESB_BIT] == $past(|(esr & ese));
	endproperty
	a_esb_bit: assert property (p_esb_bit) else $error("event summary wrong"); // [R4]

	property p_mss_bit;
		rd_stb |=> o_avs.readdata[STB_RQS_BIT] == $past(master_summary_flag);
	endproperty
	a_mss_bit: assert property (p_mss_bit) else $error("query bit 6 wrong"); // [R6]

	property p_srq_rise;
		master_summary_flag && !mss_q |=> o_srq;
	endproperty
	a_srq_rise: assert property (p_srq_rise) else $error("request not raised"); // [R7]

	property p_poll_clear;
		rd_poll && request_service_flag && !(master_summary_flag && !mss_q) |=> !o_srq ##0 o_avs.readdata[STB_RQS_BIT];
	endproperty
	a_poll_clear: assert property (p_poll_clear) else $error("poll did not clear flag"); // [R8]

	property p_query_keep;
		rd_stb && request_service_flag |=> o_srq;
	endproperty
	a_query_keep: assert property (p_query_keep) else $error("query cleared flag"); // [R10]

	property p_zero_mask;
		(sre == 8'h00) && !o_srq |=> !o_srq;
	endproperty
	a_zero_mask: assert property (p_zero_mask) else $error("request with empty mask"); // [R12]

	property p_mav_bit;
		rd_stb |=> o_avs.readdata[STB_MAV_BIT] == ($past(q_count) != '0);
	endproperty
	a_mav_bit: assert property (p_mav_bit) else $error("message flag wrong"); // [R13]

	property p_cls_queue;
		cls_op |=> (q_count == '0) && o_msg_ready;
	endproperty
	a_cls_queue: assert property (p_cls_queue) else $error("queue not emptied"); // [R15]

	property p_load_masks;
		(state == ST_LOAD) && nv_psc_s |=> (ese == 8'h00) && (sre == 8'h00) && o_nv_psc;
	endproperty
	a_load_masks: assert property (p_load_masks) else $error("masks not zeroed"); // [R19]

	c_poll: cover property (rd_poll && request_service_flag);
	c_esr_read: cover property (rd_esr && esr[ESR_PON_BIT]);
	c_queue_full: cover property (!o_msg_ready ##[1:20] rd_msg);
	c_sys_err: cover property (msg_take && i_msg_err && err_full);

endmodule : isr_status_top

// File: tb_instrument_status_reporting.sv
// self-checking bench of the status reporting block
`timescale 1ns/10ps
module tb_instrument_status_reporting;
	import isr_pkg::*;
	// arbitrary code, handed to the design as its parameter
	localparam logic [7:0] SYS_ERR_CODE_V = 8'hEE;
	localparam int Q_DEPTH_V = 16;
	logic clk, rst, go, rd, done, mv, me, npsc, srq, rdy, nvp;
	logic [7:0] addr, md, nese, nsre, acc, v, b, nve, nvs;
	logic [31:0] wdata, rdata;
	logic [15:0] abn, norm, c, m;
	isr_avs_req_t req;
	isr_avs_rsp_t rsp;
	logic [7:0] q [3];
	int miscompares, samples_checked, cyc, sb;
	isr_status_top #(.Q_DEPTH(Q_DEPTH_V), .SYS_ERR_CODE(SYS_ERR_CODE_V)) u_isr_status_top (
		.i_sys_clk(clk), .i_rst(rst), .i_avs(req), .o_avs(rsp),
		.i_abn_cond(abn), .i_norm_cond(norm), .i_std_evt(v), .i_msg_valid(mv),
		.i_msg_data(md), .i_msg_err(me), .o_msg_ready(rdy), .i_nv_psc(npsc), .i_nv_ese(nese),
		.i_nv_sre(nsre), .o_nv_psc(nvp), .o_nv_ese(nve), .o_nv_sre(nvs), .o_srq(srq));
	isr_ctl_model u_isr_ctl_model (.i_sys_clk(clk), .i_rst(rst), .i_go(go), .i_rd(rd),
		.i_addr(addr), .i_wdata(wdata), .i_avs(rsp), .o_avs(req), .o_done(done),
		.o_rdata(rdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task end_sim;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task bus(input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		go <= 1'b1;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		do @(negedge clk); while (done !== 1'b1);
	endtask : bus
	task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b1, a, 32'h0);
		chk(n, e, rdata);
	endtask : rdc
	task do_reset(input logic p);
		@(posedge clk);
		rst <= 1'b1;
		npsc <= p;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	function automatic logic [31:0] grp_stb(input logic [15:0] cc, input logic [15:0] mm,
		input int s);
		grp_stb = {31'h0, |(cc & mm)} << s;
	endfunction : grp_stb
	task push(input logic [7:0] d, input logic e);
		@(posedge clk);
		mv <= 1'b1;
		md <= d;
		me <= e;
		@(posedge clk);
		mv <= 1'b0;
	endtask : push
	initial begin
		void'($urandom(63));
		rst = 1'b1;
		{go, rd, mv, me, npsc, addr, md, wdata, abn, norm, v, acc} = '0;
		nese = 8'($urandom);
		nsre = 8'($urandom);
		do_reset(1'b0);
		rdc(ADR_ESE, {24'h0, nese}, "ese");
		rdc(ADR_SRE, {24'h0, nsre & SRE_MASK}, "sre");
		chk("nv_ese", {24'h0, nese}, {24'h0, nve});
		chk("nv_sre", {24'h0, nsre & SRE_MASK}, {24'h0, nvs});
		chk("nv_psc", 32'h0, {31'h0, nvp});
		rdc(ADR_ESR, 32'h80, "esr");
		do_reset(1'b1);
		rdc(ADR_ESE, 32'h0, "ese");
		rdc(ADR_SRE, 32'h0, "sre");
		chk("nv_psc", 32'h1, {31'h0, nvp});
		rdc(ADR_STB, 32'h0, "stb");
		bus(1'b0, ADR_PSC, 32'h0);
		rdc(ADR_PSC, 32'h0, "psc");
		chk("nv_psc", 32'h0, {31'h0, nvp});
		bus(1'b0, ADR_ESE, 32'hFF);
		repeat (20) begin
			@(posedge clk);
			v <= 8'($urandom);
			@(negedge clk);
			acc = acc | v;
			chk("srq", 32'h0, {31'h0, srq});
		end
		@(posedge clk);
		v <= 8'h0;
		// power-loss request setup
		// controller mask setup
		bus(1'b0, ADR_ESE, 32'h80);
		bus(1'b0, ADR_SRE, 32'h20);
		rdc(ADR_STB, 32'h60, "stb");
		chk("srq", 32'h1, {31'h0, srq});
		rdc(ADR_POLL, 32'h60, "poll");
		rdc(ADR_POLL, 32'h20, "poll");
		chk("srq", 32'h0, {31'h0, srq});
		rdc(ADR_STB, 32'h60, "stb");
		rdc(ADR_ESR, {24'h0, acc | 8'h80}, "esr");
		bus(1'b0, ADR_ESR, 32'hFF);
		rdc(ADR_ESR, 32'h0, "esr");
		rdc(ADR_STB, 32'h0, "stb");
		for (int g = 0; g < 2; g++) begin
			b = g ? ADR_NORM_BASE : ADR_ABN_BASE;
			sb = g ? STB_NORM_BIT : STB_ABN_BIT;
			c = 16'($urandom) | 16'h1;
			m = 16'($urandom);
			bus(1'b0, b + GRP_ENABLE, {16'h0, m});
			@(posedge clk);
			if (g) begin
				norm <= c;
			end else begin
				abn <= c;
			end
			repeat (4) @(posedge clk);
			rdc(ADR_STB, grp_stb(c, m, sb), "stb");
			rdc(b + GRP_EVENT, {16'h0, c}, "event");
			rdc(ADR_STB, 32'h0, "stb");
			bus(1'b0, b + GRP_RISE, 32'h0);
			bus(1'b0, b + GRP_FALL, 32'hFFFF);
			@(posedge clk);
			if (g) begin
				norm <= '0;
			end else begin
				abn <= '0;
			end
			repeat (4) @(posedge clk);
			rdc(b + GRP_EVENT, {16'h0, c}, "event");
			rdc(b + GRP_COND, 32'h0, "cond");
			bus(1'b0, ADR_PRESET, 32'h0);
			rdc(b + GRP_RISE, 32'hFFFF, "rise");
			rdc(b + GRP_FALL, 32'h0, "fall");
			rdc(b + GRP_ENABLE, 32'h0, "enable");
		end
		for (int i = 0; i < 3; i++) begin
			q[i] = 8'($urandom);
			push(q[i], 1'b0);
		end
		rdc(ADR_STB, 32'h10, "stb");
		for (int i = 0; i < 3; i++) begin
			rdc(ADR_MSG, {23'h0, 1'b1, q[i]}, "msg");
		end
		rdc(ADR_STB, 32'h0, "stb");
		for (int i = 0; i < 6; i++) begin
			push(8'(8'h30 + i), 1'b1);
		end
		for (int i = 0; i < 5; i++) begin
			rdc(ADR_MSG, {23'h0, 1'b1, i < 4 ? 8'(8'h30 + i) : SYS_ERR_CODE_V}, "msg");
		end
		bus(1'b1, ADR_MSG, 32'h0);
		chk("mav", 32'h0, {31'h0, rdata[MSG_VALID_BIT]});
		for (int i = 0; i < Q_DEPTH_V; i++) begin
			push(8'(i), 1'b0);
		end
		@(negedge clk);
		chk("ready", 32'h0, {31'h0, rdy});
		bus(1'b0, ADR_CLS, 32'h0);
		rdc(ADR_STB, 32'h0, "stb");
		chk("ready", 32'h1, {31'h0, rdy});
		end_sim();
	end
endmodule : tb_instrument_status_reporting
